// ---- verilog/probe_if_pkg.sv ----
`default_nettype none
package probe_if_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS     = 50;
  localparam int unsigned FLASH_HALF_NS     = 250_000_000;
  localparam int unsigned FLASH_HALF_CYCLES = FLASH_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned SAMPLES_PER_SYNC  = 256;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam int unsigned AXI_ADDR_W        = 8;
  localparam logic [7:0]  CTRL_OFFSET       = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET     = 8'h04;
  localparam logic [7:0]  IRQ_STATUS_OFFSET = 8'h08;
  localparam logic [7:0]  IRQ_ENABLE_OFFSET = 8'h0C;
  localparam logic [7:0]  IRQ_CLEAR_OFFSET  = 8'h10;

  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // control register fields
  localparam int unsigned CTRL_WIDTH        = 12;
  localparam int unsigned CTRL_USB          = 0;
  localparam int unsigned CTRL_LASER        = 1;
  localparam int unsigned CTRL_STARTUP      = 2;
  localparam int unsigned CTRL_MASTER       = 3;
  localparam int unsigned CTRL_STATS        = 4;
  localparam int unsigned CTRL_SNAP         = 5;
  localparam int unsigned CTRL_BNC_DIR      = 6;
  localparam int unsigned CTRL_EXT_DIR      = 7;
  localparam int unsigned CTRL_BNC_VAL      = 8;
  localparam int unsigned CTRL_EXT_VAL      = 9;
  localparam int unsigned CTRL_STREAM_MST   = 10;
  localparam int unsigned CTRL_STREAM_EN    = 11;
  localparam logic [11:0] CTRL_RESET        = 12'h000;

  ////////////////////////////////////////////////////////////////////////////
  // status and interrupt layout
  localparam int unsigned STATUS_WIDTH      = 15;
  localparam int unsigned IRQ_WIDTH         = 6;
  localparam int unsigned IRQ_TEMP          = 0;
  localparam int unsigned IRQ_LINK          = 1;
  localparam int unsigned IRQ_TRIG_BNC      = 2;
  localparam int unsigned IRQ_TRIG_EXT      = 3;
  localparam int unsigned IRQ_SNAP          = 4;
  localparam int unsigned IRQ_SYNC          = 5;
  localparam logic [5:0]  IRQ_RESET         = 6'h00;

  localparam int unsigned PIN_COUNT         = 9;

  typedef enum logic [1:0] {
    LED_OFF   = 2'b00,
    LED_ON    = 2'b01,
    LED_FLASH = 2'b10
  } led_mode_t;

endpackage
`default_nettype wire

// ---- verilog/sync_two_ff.sv ----
`default_nettype none
module sync_two_ff #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  // first stage is read by the second stage only
  logic [WIDTH-1:0] meta;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule
`default_nettype wire

// ---- verilog/probe_if_status.sv ----
//
// Behaviour
// - main switch on, interface inactive: power indicator flashes
// - usb session with server established: power indicator steadily lit
// - no power or firmware bad: power indicator dark
// - laser temperature regulated in range: temperature indicator off
// - laser too hot: cool it, temperature indicator steadily lit
// - laser too cold: heat it, temperature indicator flashes
// - supply laser off: laser indicator dark
// - start-up or mode change: laser indicator flashes, fast shutdown disarmed
// - running in requested mode: laser indicator steady, fast shutdown armed
// - no probe data arriving: data-link indicator off
// - optical link failure while the laser runs: laser switched off, data-link indicator flashes
// - probe data being received: data-link indicator steadily lit
// - master drives statistics enable and snapshot lines, slaves follow them
// - each unit drives a line telling whether it is master or slave
// - two independent trigger ports, single-ended and differential, in or out
// - stream master pulses once per 256 samples, slaves pace to pulses
//
`default_nettype none
module probe_if_status #(
  parameter int unsigned FLASH_HALF_CYCLES = probe_if_pkg::FLASH_HALF_CYCLES,
  parameter int unsigned SAMPLES_PER_SYNC  = probe_if_pkg::SAMPLES_PER_SYNC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  input  wire logic        fw_ok,
  input  wire logic        temp_high,
  input  wire logic        temp_low,
  input  wire logic        link_fail,
  input  wire logic        probe_data,
  input  wire logic        stats_in,
  input  wire logic        snap_in,
  input  wire logic        trig_bnc_in,
  input  wire logic        trig_ext_in,
  input  wire logic        sample_tick,
  output var  logic        led_power,
  output var  logic        led_temp,
  output var  logic        led_laser,
  output var  logic        led_link,
  output var  logic        laser_on,
  output var  logic        fast_shutdown_armed,
  output var  logic        laser_cool,
  output var  logic        laser_heat,
  output var  logic        master_out,
  output var  logic        stats_out,
  output var  logic        stats_oe,
  output var  logic        snap_out,
  output var  logic        snap_oe,
  output var  logic        stats_active,
  output var  logic        snapshot,
  output var  logic        trig_bnc_out,
  output var  logic        trig_bnc_oe,
  output var  logic        trig_ext_p,
  output var  logic        trig_ext_n,
  output var  logic        trig_ext_oe,
  output var  logic        sample_pace,
  output var  logic        irq
);

  localparam int unsigned SYNC_W = $clog2(SAMPLES_PER_SYNC);
  localparam logic [SYNC_W-1:0] SYNC_LAST = SYNC_W'(SAMPLES_PER_SYNC - 1);
  localparam logic [31:0] FLASH_LAST = 32'(FLASH_HALF_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edges

  logic [8:0] pins_s;
  logic [8:0] pins_prev;
  wire        fw_ok_s   = pins_s[0];
  wire        hot_s     = pins_s[1];
  wire        cold_s    = pins_s[2];
  wire        fail_s    = pins_s[3];
  wire        probe_s   = pins_s[4];
  wire        stats_s   = pins_s[5];
  wire        snap_s    = pins_s[6];
  wire        bnc_s     = pins_s[7];
  wire        ext_s     = pins_s[8];
  wire [8:0]  pins_rise = pins_s & ~pins_prev;

  sync_two_ff #(.WIDTH(probe_if_pkg::PIN_COUNT)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({trig_ext_in, trig_bnc_in, snap_in, stats_in, probe_data,
                link_fail, temp_low, temp_high, fw_ok}),
    .q       (pins_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [11:0] ctrl;
  logic [5:0]  irq_status;
  logic [5:0]  irq_enable;
  logic        link_failed;
  logic        snap_req;
  logic [31:0] flash_cnt;
  logic        flash_phase;
  logic [SYNC_W-1:0] sync_cnt;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  wire usb_up    = ctrl[probe_if_pkg::CTRL_USB];
  wire laser_en  = ctrl[probe_if_pkg::CTRL_LASER];
  wire startup   = ctrl[probe_if_pkg::CTRL_STARTUP];
  wire is_master = ctrl[probe_if_pkg::CTRL_MASTER];
  wire strm_mst  = ctrl[probe_if_pkg::CTRL_STREAM_EN] &
                   ctrl[probe_if_pkg::CTRL_STREAM_MST];
  wire strm_slv  = ctrl[probe_if_pkg::CTRL_STREAM_EN] &
                   ~ctrl[probe_if_pkg::CTRL_STREAM_MST];

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path: address and data taken in either order

  wire aw_take  = awvalid & awready;
  wire w_take   = wvalid & wready;
  wire wr_fire  = ~awready & ~wready & ~bvalid;
  wire b_done   = bvalid & bready;
  wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                       {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire hit_ctrl  = aw_addr_q == probe_if_pkg::CTRL_OFFSET;
  wire hit_en    = aw_addr_q == probe_if_pkg::IRQ_ENABLE_OFFSET;
  wire hit_clr   = aw_addr_q == probe_if_pkg::IRQ_CLEAR_OFFSET;
  wire hit_ro    = aw_addr_q == probe_if_pkg::STATUS_OFFSET ||
                   aw_addr_q == probe_if_pkg::IRQ_STATUS_OFFSET;
  wire wr_ok     = hit_ctrl | hit_en | hit_clr | hit_ro;
  wire wr_ctrl   = wr_fire & hit_ctrl;
  wire [31:0] merged = (32'(ctrl) & ~wmask) | (w_data_q & wmask);
  wire [11:0] next_ctrl = wr_ctrl ? merged[11:0] : ctrl;
  wire [5:0]  next_irq_enable = (wr_fire & hit_en) ?
       (irq_enable & ~wmask[5:0]) | (w_data_q[5:0] & wmask[5:0]) : irq_enable;
  wire [5:0]  clear_mask = (wr_fire & hit_clr) ? w_data_q[5:0] & wmask[5:0]
                                               : 6'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= probe_if_pkg::RESP_OKAY;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (aw_take) begin
        awready   <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (w_take) begin
        wready   <= 1'b0;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= wr_ok ? probe_if_pkg::RESP_OKAY : probe_if_pkg::RESP_SLVERR;
      end
      if (b_done) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path: answer one cycle after the address is taken

  logic [14:0] status_word;
  wire ar_take  = arvalid & arready;
  wire r_done   = rvalid & rready;
  // snapshot request is self-clearing, so it reads back as zero
  wire [31:0] ctrl_rd = 32'(ctrl & ~(12'h001 << probe_if_pkg::CTRL_SNAP));
  wire rd_ctrl  = araddr == probe_if_pkg::CTRL_OFFSET;
  wire rd_stat  = araddr == probe_if_pkg::STATUS_OFFSET;
  wire rd_ists  = araddr == probe_if_pkg::IRQ_STATUS_OFFSET;
  wire rd_ien   = araddr == probe_if_pkg::IRQ_ENABLE_OFFSET;
  wire rd_clr   = araddr == probe_if_pkg::IRQ_CLEAR_OFFSET;
  wire rd_ok    = rd_ctrl | rd_stat | rd_ists | rd_ien | rd_clr;
  wire [31:0] rd_mux = rd_ctrl ? ctrl_rd :
                       rd_stat ? 32'(status_word) :
                       rd_ists ? 32'(irq_status) :
                       rd_ien  ? 32'(irq_enable) : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= probe_if_pkg::RESP_OKAY;
    end else if (ar_take) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_mux;
      rresp   <= rd_ok ? probe_if_pkg::RESP_OKAY : probe_if_pkg::RESP_SLVERR;
    end else if (r_done) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicator modes and flash prescaler

  wire flash_tick = flash_cnt == FLASH_LAST;

  // a failure only latches while the laser runs; it holds the laser off
  // until software withdraws the laser enable, so the fault is not missed
  wire fail_evt         = fail_s & laser_on;
  wire next_link_failed = fail_evt | (link_failed & laser_en);
  wire next_laser_on    = laser_en & ~next_link_failed;
  wire link_quiet       = ~next_link_failed & ~probe_s;

  probe_if_pkg::led_mode_t power_mode;
  probe_if_pkg::led_mode_t temp_mode;
  probe_if_pkg::led_mode_t laser_mode;
  probe_if_pkg::led_mode_t link_mode;

  assign power_mode = !fw_ok_s ? probe_if_pkg::LED_OFF :
                      usb_up   ? probe_if_pkg::LED_ON  :
                                 probe_if_pkg::LED_FLASH;
  assign temp_mode  = hot_s  ? probe_if_pkg::LED_ON    :
                      cold_s ? probe_if_pkg::LED_FLASH :
                               probe_if_pkg::LED_OFF;
  assign laser_mode = !next_laser_on ? probe_if_pkg::LED_OFF :
                      startup ? probe_if_pkg::LED_FLASH :
                                probe_if_pkg::LED_ON;
  assign link_mode  = next_link_failed ? probe_if_pkg::LED_FLASH :
                      probe_s ? probe_if_pkg::LED_ON :
                                probe_if_pkg::LED_OFF;

  function automatic logic led_level(input probe_if_pkg::led_mode_t mode,
                                     input logic phase);
    case (mode)
      probe_if_pkg::LED_OFF:   led_level = 1'b0;
      probe_if_pkg::LED_ON:    led_level = 1'b1;
      probe_if_pkg::LED_FLASH: led_level = phase;
      default:                 led_level = 1'b0;
    endcase
  endfunction

  wire next_phase = flash_tick ? ~flash_phase : flash_phase;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_cnt   <= 32'h0000_0000;
      flash_phase <= 1'b0;
    end else begin
      flash_cnt   <= flash_tick ? 32'h0000_0000 : flash_cnt + 32'h0000_0001;
      flash_phase <= next_phase;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_power   <= 1'b0;
      led_temp    <= 1'b0;
      led_laser   <= 1'b0;
      led_link    <= 1'b0;
      laser_on    <= 1'b0;
      link_failed <= 1'b0;
      fast_shutdown_armed <= 1'b0;
      laser_cool  <= 1'b0;
      laser_heat  <= 1'b0;
    end else begin
      led_power   <= led_level(power_mode, next_phase);
      led_temp    <= led_level(temp_mode, next_phase);
      led_laser   <= led_level(laser_mode, next_phase);
      led_link    <= led_level(link_mode, next_phase);
      laser_on    <= next_laser_on;
      link_failed <= next_link_failed;
      fast_shutdown_armed <= next_laser_on & ~startup;
      laser_cool  <= hot_s;
      laser_heat  <= cold_s & ~hot_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multiprobe link, triggers and stream pacing

  wire sync_due   = strm_mst & sample_tick & (sync_cnt == SYNC_LAST);
  wire sync_rx    = strm_slv & pins_rise[8];
  wire snap_rx    = ~is_master & pins_rise[6];
  wire ext_level  = strm_mst ? sync_due : ctrl[probe_if_pkg::CTRL_EXT_VAL];
  wire temp_rise  = (hot_s | cold_s) & ~(pins_prev[1] | pins_prev[2]);

  wire [5:0] events = {sync_rx, snap_rx, pins_rise[8], pins_rise[7],
                       next_link_failed & ~link_failed, temp_rise};
  // a new event beats a clear written in the same cycle
  wire [5:0] next_irq_status = (irq_status & ~clear_mask) | events;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl         <= probe_if_pkg::CTRL_RESET;
      snap_req     <= 1'b0;
      pins_prev    <= 9'h000;
      sync_cnt     <= '0;
      irq_status   <= probe_if_pkg::IRQ_RESET;
      irq_enable   <= probe_if_pkg::IRQ_RESET;
      irq          <= 1'b0;
      master_out   <= 1'b0;
      stats_out    <= 1'b0;
      stats_oe     <= 1'b0;
      snap_out     <= 1'b0;
      snap_oe      <= 1'b0;
      stats_active <= 1'b0;
      snapshot     <= 1'b0;
      trig_bnc_out <= 1'b0;
      trig_bnc_oe  <= 1'b0;
      trig_ext_p   <= 1'b0;
      trig_ext_n   <= 1'b1;
      trig_ext_oe  <= 1'b0;
      sample_pace  <= 1'b0;
    end else begin
      // the snapshot bit is a strobe: keeping it would let a later write
      // with byte 0 masked off fire a second snapshot
      ctrl         <= next_ctrl & ~(12'h001 << probe_if_pkg::CTRL_SNAP);
      snap_req     <= wr_ctrl & merged[probe_if_pkg::CTRL_SNAP];
      pins_prev    <= pins_s;
      if (!strm_mst) begin
        sync_cnt <= '0;
      end else if (sample_tick) begin
        sync_cnt <= sync_cnt + SYNC_W'(1);
      end
      irq_status   <= next_irq_status;
      irq_enable   <= next_irq_enable;
      irq          <= |(next_irq_status & next_irq_enable);
      master_out   <= is_master;
      stats_out    <= ctrl[probe_if_pkg::CTRL_STATS];
      stats_oe     <= is_master;
      snap_out     <= is_master & snap_req;
      snap_oe      <= is_master;
      stats_active <= is_master ? ctrl[probe_if_pkg::CTRL_STATS]
                                : stats_s;
      snapshot     <= is_master ? snap_req : snap_rx;
      trig_bnc_out <= ctrl[probe_if_pkg::CTRL_BNC_VAL];
      trig_bnc_oe  <= ctrl[probe_if_pkg::CTRL_BNC_DIR];
      trig_ext_p   <= ext_level;
      trig_ext_n   <= ~ext_level;
      trig_ext_oe  <= ctrl[probe_if_pkg::CTRL_EXT_DIR] | strm_mst;
      sample_pace  <= sync_due | sync_rx;
    end
  end

  assign status_word = {fw_ok_s, ext_s, bnc_s, stats_active, is_master,
                        cold_s, hot_s, probe_s, link_failed,
                        fast_shutdown_armed, laser_on,
                        led_link, led_laser, led_temp, led_power};

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  power_dark_a: assert property (!fw_ok_s |=> !led_power)
    else $error("power indicator lit without valid firmware");
  power_steady_a: assert property (fw_ok_s && usb_up |=> led_power)
    else $error("power indicator not steady with usb session");
  flash_rate_a: assert property (flash_tick |=> flash_phase != $past(flash_phase))
    else $error("flash phase did not toggle on prescaler tick");
  temp_hot_a: assert property (hot_s |=> led_temp && laser_cool)
    else $error("overheated laser not cooled or not shown");
  temp_ok_a: assert property (!hot_s && !cold_s |=> !led_temp && !laser_cool && !laser_heat)
    else $error("temperature indicator or regulation active in range");
  laser_dark_a: assert property (!laser_on |-> !led_laser)
    else $error("laser indicator lit with laser off");
  armed_steady_a: assert property (fast_shutdown_armed |-> laser_on && led_laser)
    else $error("shutdown armed without steady laser indicator");
  startup_disarm_a: assert property (laser_on && $past(startup) |-> !fast_shutdown_armed)
    else $error("fast shutdown armed during start-up");
  link_off_a: assert property (fail_s && laser_on |=> !laser_on && link_failed)
    else $error("laser kept on after link failure");
  link_quiet_a: assert property ($past(link_quiet) |-> !led_link)
    else $error("data-link indicator lit without data");
  sync_pulse_a: assert property (sync_due |=> sample_pace && trig_ext_oe)
    else $error("stream sync pulse not emitted");
  slave_follow_a: assert property (!is_master |=> stats_active == $past(stats_s))
    else $error("slave statistics state does not follow link");
  master_line_a: assert property (##1 master_out == $past(is_master))
    else $error("master status line wrong");
  irq_level_a: assert property (irq == |(irq_status & irq_enable))
    else $error("interrupt output disagrees with status and enable");

endmodule
`default_nettype wire

// ---- verilog/_unused_placeholder_never.sv ----
`default_nettype none
`default_nettype wire

// ---- bench/link_peer.sv ----
`default_nettype none
// another unit acting as master on the multi-unit link
module link_peer (
  input  wire logic       aclk,
  input  wire logic       stats_req,
  input  wire logic       snap_req,
  input  wire logic       sync_go,
  input  wire logic [3:0] gap,
  output var  logic       stats_line,
  output var  logic       snap_line,
  output var  logic       sync_line,
  output var  logic [7:0] sent
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  logic       snap_d;
  initial begin
    {stats_line, snap_line, sync_line, sent, cnt, snap_d} = '0;
  end
  // gap sets how slowly sync pulses follow each other
  always @(posedge aclk) begin
    stats_line <= stats_req;
    snap_d <= snap_req;
    snap_line <= snap_req & ~snap_d;
    cnt <= (sync_go && cnt != gap) ? cnt + 4'h1 : 4'h0;
    sync_line <= sync_go && cnt == gap;
    if (sync_go && cnt == gap) sent <= sent + 8'h01;
  end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, sample_tick = 0, bnc_drv = 0;
  logic        fw_ok = 0, temp_high = 0, temp_low = 0, link_fail = 0;
  logic        probe_data = 0, p_stats = 0, p_snap = 0, p_sync = 0;
  logic [7:0]  awaddr = 0, araddr = 0, s0;
  logic [31:0] wdata = 0, r;
  logic [3:0]  wstrb = 4'hF, gap = 4'h4;
  wire logic   awready, wready, bvalid, arready, rvalid, irq, led_power,
    led_temp, led_laser, led_link, laser_on, fast_shutdown_armed, laser_cool,
    laser_heat, master_out, stats_out, stats_oe, snap_out, snap_oe,
    stats_active, snapshot, trig_bnc_out, trig_bnc_oe, trig_ext_p,
    trig_ext_n, trig_ext_oe, sample_pace, stats_l, snap_l, sync_l;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [7:0]  sent;
  wire logic [3:0]  leds = {led_link, led_laser, led_temp, led_power};
  // wire levels: whoever enables its driver owns the line
  wire logic stats_in = stats_oe ? stats_out : stats_l;
  wire logic snap_in = snap_oe ? snap_out : snap_l;
  wire logic trig_ext_in = trig_ext_oe ? trig_ext_p : sync_l;
  wire logic trig_bnc_in = trig_bnc_oe ? trig_bnc_out : bnc_drv;
  int          n_mismatch = 0, cmp_count = 0, n_pace = 0, n_snap = 0;
  logic [33:0] exp_q[$];
  probe_if_status #(.FLASH_HALF_CYCLES(4), .SAMPLES_PER_SYNC(4)) i_probe_if_status (.*);
  link_peer i_link_peer (.aclk, .stats_req(p_stats), .snap_req(p_snap),
    .sync_go(p_sync), .gap, .stats_line(stats_l), .snap_line(snap_l),
    .sync_line(sync_l), .sent);
  always #25 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [33:0] s, input logic [33:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] p);
    exp_q.push_back({p, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // counts lamp changes; a steady lamp must not change at all
  task automatic look(input int b, input probe_if_pkg::led_mode_t m);
    int   ch;
    logic p;
    ch = 0;
    repeat (6) @(posedge aclk);
    p = leds[b];
    repeat (40) begin
      @(posedge aclk);
      if (leds[b] !== p) ch++;
      p = leds[b];
    end
    if (m == probe_if_pkg::LED_FLASH)
      cmp(34'(ch >= 7 && ch <= 11), 34'h1);
    else
      cmp(34'({ch, p}), 34'(m == probe_if_pkg::LED_ON));
  endtask
  always @(posedge aclk) begin
    if (rvalid && rready) cmp({rresp, rdata}, exp_q.pop_front());
    if (sample_pace === 1'b1) n_pace++;
    n_snap += int'(snapshot === 1'b1) + int'(snap_out === 1'b1);
  end
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    summarize();
  end
  initial begin
    void'($urandom(45718));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    look(0, probe_if_pkg::LED_OFF);
    fw_ok <= 1'b1;
    look(0, probe_if_pkg::LED_FLASH);
    wr(8'h00, 32'h0000_0001);
    look(0, probe_if_pkg::LED_ON);
    r = $urandom;
    wr(8'h0C, r);
    rd(8'h0C, {26'h0, r[5:0]}, 2'h0);
    rd(8'h14, 32'h0, 2'h2);
    wr(8'h0C, 32'h0);
    $display("power and register test done");
    temp_high <= 1'b1;
    look(1, probe_if_pkg::LED_ON);
    cmp(34'({laser_cool, irq}), 34'h2);
    rd(8'h08, 32'h1, 2'h0);
    wr(8'h0C, 32'h1);
    repeat (3) @(posedge aclk);
    cmp(34'(irq), 34'h1);
    wr(8'h10, 32'h1);
    repeat (3) @(posedge aclk);
    cmp(34'(irq), 34'h0);
    wr(8'h0C, 32'h0);
    temp_high <= 1'b0;
    temp_low <= 1'b1;
    look(1, probe_if_pkg::LED_FLASH);
    cmp(34'(laser_heat), 34'h1);
    temp_low <= 1'b0;
    look(1, probe_if_pkg::LED_OFF);
    $display("temperature test done");
    wr(8'h00, 32'h0000_0007);
    look(2, probe_if_pkg::LED_FLASH);
    cmp(34'({laser_on, fast_shutdown_armed}), 34'h2);
    wr(8'h00, 32'h0000_0003);
    look(2, probe_if_pkg::LED_ON);
    cmp(34'(fast_shutdown_armed), 34'h1);
    probe_data <= 1'b1;
    look(3, probe_if_pkg::LED_ON);
    probe_data <= 1'b0;
    look(3, probe_if_pkg::LED_OFF);
    link_fail <= 1'b1;
    look(3, probe_if_pkg::LED_FLASH);
    cmp(34'(laser_on), 34'h0);
    look(2, probe_if_pkg::LED_OFF);
    link_fail <= 1'b0;
    wr(8'h00, 32'h0000_0019);
    repeat (4) @(posedge aclk);
    cmp(34'({master_out, stats_oe, stats_out, stats_active}), 34'hF);
    n_snap = 0;
    wr(8'h00, 32'h0000_0039);
    repeat (2) @(posedge aclk);
    cmp(34'(n_snap), 34'h2);
    $display("laser, link and master test done");
    wr(8'h00, 32'h0000_0001);
    p_stats <= 1'b1;
    wr(8'h10, 32'h0000_003F);
    n_snap = 0;
    p_snap <= 1'b1;
    repeat (6) @(posedge aclk);
    cmp(34'({master_out, stats_oe, stats_active}), 34'h1);
    cmp(34'(n_snap), 34'h1);
    // slave: master status line low while the statistics line is on
    cmp(34'({master_out, stats_in}), 34'h1);
    rd(8'h08, 32'h10, 2'h0);
    wr(8'h00, 32'h0000_03C1);
    repeat (4) @(posedge aclk);
    cmp(34'({trig_bnc_oe, trig_bnc_out, trig_ext_oe, trig_ext_p, trig_ext_n}), 34'h1E);
    wr(8'h00, 32'h0000_0001);
    repeat (4) @(posedge aclk);
    wr(8'h10, 32'h0000_003F);
    bnc_drv <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(8'h08, 32'h4, 2'h0);
    $display("slave and trigger test done");
    wr(8'h00, 32'h0000_0C01);
    n_pace = 0;
    repeat (8) begin
      sample_tick <= 1'b1;
      @(posedge aclk);
      sample_tick <= 1'b0;
      @(posedge aclk);
    end
    repeat (4) @(posedge aclk);
    cmp(34'(n_pace), 34'h2);
    wr(8'h00, 32'h0000_0801);
    wr(8'h10, 32'h0000_003F);
    n_pace = 0;
    s0 = sent;
    gap <= 4'($urandom_range(4, 12));
    p_sync <= 1'b1;
    repeat (60) @(posedge aclk);
    p_sync <= 1'b0;
    repeat (8) @(posedge aclk);
    cmp(34'(n_pace), 34'(sent - s0));
    rd(8'h08, 32'h28, 2'h0);
    $display("stream sync test done");
    summarize();
  end
endmodule
`default_nettype wire
